// ===== logic/pin_interrupt_pattern_match.sv
// module: pin interrupts, pattern match engine and grouped interrupts
//
// Function
// - up to eight pins, rise/fall/both edges
// - level mode, active low or high
// - eight match inputs from ports 0/1
// - expression of levels and transitions
// - each product term has own request
// - any match raises event notify, pin-routable
// - match wakes only active or sleep
// - two grouped units, AND or OR
`timescale 1ns/1ps
module pin_interrupt_pattern_match
    import pint_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // digital pins of ports 0 and 1
    input wire logic [PORT_W-1:0] i_pins,
    // pin interrupt setup and clear
    input wire pin_cfg_t [N_PIN-1:0] i_pin_cfg,
    input wire logic [N_PIN-1:0] i_pin_clr,
    // pattern match setup
    input wire logic i_pm_enable,
    input wire slice_cfg_t [N_SLICE-1:0] i_slice_cfg,
    input wire logic [N_SLICE-1:0] i_slice_clr,
    input wire logic i_event_enable,
    input wire logic i_event_pin_enable,
    input wire logic i_deep_lowpower,
    // grouped input interrupt setup
    input wire grp_cfg_t [N_GRP-1:0] i_grp_cfg,
    // requests
    output logic [N_PIN-1:0] o_pin_irq,
    output logic [N_SLICE-1:0] o_term_irq,
    output logic o_cpu_event_notify,
    output logic o_event_pin,
    output logic o_wake,
    output logic [N_GRP-1:0] o_grouped_input_interrupt
);
    logic [PORT_W-1:0] meta_reg;  // first synchroniser stage
    logic [PORT_W-1:0] sync_reg;  // synchronised pins
    logic [PORT_W-1:0] prev_reg;  // synchronised pins, one cycle older
    logic [N_PIN-1:0] pend_reg;   // sticky edge or live level requests
    logic [N_PIN-1:0] pin_irq_next;
    logic [N_SLICE-1:0] slice_true;
    logic [N_SLICE-1:0] term_next;
    logic [N_SLICE-1:0] term_reg;
    logic any_match_reg;
    logic [N_GRP-1:0] grp_next;
    logic [N_PIN-1:0] pin_cur;  // chosen pin level per request
    logic [N_PIN-1:0] pin_prev;  // same, one cycle older
    logic [N_SLICE-1:0] slice_cur;  // chosen input level per slice
    logic [N_SLICE-1:0] slice_prev;  // same, one cycle older

    ////////////////////////////////////////////////////////////////////////
    // pick one pin out of ports 0 and 1 by its index (port*32+pin)
    // six bits cover both ports, so every index is a real pin
    function automatic logic pick_pin(
        input logic [PORT_W-1:0] levels,  // one level per pin
        input logic [SEL_W-1:0] idx  // pin index
    );
        pick_pin = levels[idx];
    endfunction : pick_pin

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, then history for edges
    // pins come from outside the clock domain; only sync_reg and later
    // stages are read, so the first flop has a full cycle to settle
    // a pin pulse shorter than one clock period may never be seen
    // while i_ce is low all three stages hold, so a pin change in that
    // time is judged only once the enable returns
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else if (i_ce) begin
            meta_reg <= i_pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // route the chosen pins to the requests and the slices
    generate
        for (genvar i = 0; i < N_PIN; i++) begin : g_pin_pick
            assign pin_cur[i] = pick_pin(sync_reg, i_pin_cfg[i].sel);
            assign pin_prev[i] = pick_pin(prev_reg, i_pin_cfg[i].sel);
        end
        for (genvar s = 0; s < N_SLICE; s++) begin : g_slice_pick
            assign slice_cur[s] = pick_pin(sync_reg, i_slice_cfg[s].sel);
            assign slice_prev[s] = pick_pin(prev_reg, i_slice_cfg[s].sel);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin interrupts: sticky edges or live levels
    // level requests follow the pin with no memory; edge requests are
    // held until cleared, and a clear meeting a new edge loses to it,
    // so no edge is dropped; a clear has no effect in level mode
    always_comb begin
        for (int i = 0; i < N_PIN; i++) begin
            logic c;
            logic p;
            c = pin_cur[i];
            p = pin_prev[i];
            if (i_pin_cfg[i].level) begin
                // level mode, polarity chosen
                pin_irq_next[i] = ~(c ^ i_pin_cfg[i].rise_hi);
            end else begin
                // edge mode, set wins over clear
                pin_irq_next[i] = (i_pin_cfg[i].rise_hi & c & ~p)
                    | (i_pin_cfg[i].fall & ~c & p)
                    | (pend_reg[i] & ~i_pin_clr[i]);
            end
        end
    end

    // request state register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_reg <= '0;
        end else if (i_ce) begin
            pend_reg <= pin_irq_next;
        end
    end

    // requests leave straight from flip-flops
    assign o_pin_irq = pend_reg;

    ////////////////////////////////////////////////////////////////////////
    // pattern match bit slices
    // each slice keeps its own edge memory, so a transition seen once
    // stays true for that slice until its clear comes
    generate
        for (genvar s = 0; s < N_SLICE; s++) begin : g_slice
            pint_slice u_slice (
                .i_clk_sys(i_clk_sys),
                .i_arst_n(i_arst_n),
                .i_ce(i_ce),
                .i_cur(slice_cur[s]),
                .i_prev(slice_prev[s]),
                .i_cond(i_slice_cfg[s].cond),
                .i_clr(i_slice_clr[s]),
                .o_true(slice_true[s])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // and slices into product terms; a term ends at an end slice
    // slices after the last end slice belong to no term and are ignored,
    // so a term without an end slice never fires
    always_comb begin
        logic acc;
        acc = 1'b1;
        for (int s = 0; s < N_SLICE; s++) begin
            acc = acc & slice_true[s];
            if (i_slice_cfg[s].end_term) begin
                term_next[s] = acc & i_pm_enable;
                acc = 1'b1;
            end else begin
                term_next[s] = 1'b0;
            end
        end
    end

    // registered term requests and match flag
    // the match flag is the or of all terms, registered with them
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            term_reg <= '0;
            any_match_reg <= 1'b0;
        end else if (i_ce) begin
            term_reg <= term_next;
            any_match_reg <= |term_next;
        end
    end

    assign o_term_irq = term_reg;
    // event notify and its pin copy
    // the match flag is registered once; notify, its pin copy and wake
    // are only gated from it, so all three move in the same cycle
    // wake is held off in deep low-power modes: the match logic must not
    // be relied on as the only way out of those modes
    assign o_cpu_event_notify = any_match_reg & i_event_enable;
    assign o_event_pin = o_cpu_event_notify & i_event_pin_enable;
    // no wake from deep low-power modes
    assign o_wake = any_match_reg & ~i_deep_lowpower;

    ////////////////////////////////////////////////////////////////////////
    // grouped input interrupts, AND or OR of chosen pins
    // an AND group with no pin enabled stays quiet instead of firing on
    // an empty product; polarity is applied per pin before combining
    always_comb begin
        for (int g = 0; g < N_GRP; g++) begin
            logic [PORT_W-1:0] act;
            act = ~(sync_reg ^ i_grp_cfg[g].pol);
            if (i_grp_cfg[g].and_mode) begin
                // all enabled pins active
                grp_next[g] = (|i_grp_cfg[g].en)
                    & &(act | ~i_grp_cfg[g].en);
            end else begin
                // any enabled pin active
                grp_next[g] = |(act & i_grp_cfg[g].en);
            end
        end
    end

    // grouped requests from flip-flops
    // a group request follows the pins; it has no memory of its own
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_grouped_input_interrupt <= '0;
        end else if (i_ce) begin
            o_grouped_input_interrupt <= grp_next;
        end
    end
endmodule : pin_interrupt_pattern_match

// ===== logic/pint_pkg.sv
// package: widths, types and modes of the pin interrupt block
package pint_pkg;
    localparam int N_PIN = 8;          // selectable interrupt pins
    localparam int N_SLICE = 8;        // pattern match inputs and slices
    localparam int N_GRP = 2;          // grouped input interrupt units
    localparam int PORT_W = 64;        // pins on ports 0 and 1
    localparam int SEL_W = 6;          // pin select index width
    localparam logic [2:0] SLICE_RESET = 3'h0;
    // slice condition codes
    typedef enum logic [2:0] {
        C_ALWAYS = 3'h0,  // slice always true
        C_HIGH = 3'h1,    // input high
        C_LOW = 3'h2,     // input low
        C_RISE = 3'h3,    // rising edge seen (sticky)
        C_FALL = 3'h4,    // falling edge seen (sticky)
        C_EDGE = 3'h5,    // either edge seen (sticky)
        C_NEVER = 3'h6    // term never true
    } cond_t;
    // per-pin interrupt setup
    typedef struct packed {
        logic [SEL_W-1:0] sel;  // pin index on ports 0/1
        logic level;            // 1 level mode, 0 edge mode
        logic rise_hi;          // edge: rise enable / level: active high
        logic fall;             // edge: fall enable
    } pin_cfg_t;
    // per-slice setup of the pattern match
    typedef struct packed {
        logic [SEL_W-1:0] sel;  // input pin index
        cond_t cond;            // condition on that input
        logic end_term;         // slice closes a product term
    } slice_cfg_t;
    // grouped input unit setup
    typedef struct packed {
        logic [PORT_W-1:0] en;   // pins taking part
        logic [PORT_W-1:0] pol;  // 1 pin counts when high
        logic and_mode;          // 1 all pins, 0 any pin
    } grp_cfg_t;
endpackage : pint_pkg

// ===== logic/pint_slice.sv
// module: one pattern match bit slice with sticky edge memory
`timescale 1ns/1ps
module pint_slice
    import pint_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // selected input, now and last cycle
    input wire logic i_cur,
    input wire logic i_prev,
    // setup and clear
    input wire cond_t i_cond,
    input wire logic i_clr,
    // slice result
    output logic o_true
);
    logic rise_reg;  // rising edge seen
    logic fall_reg;  // falling edge seen

    ////////////////////////////////////////////////////////////////////////
    // sticky edge memory; new edge wins over clear
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else if (i_ce) begin
            rise_reg <= (i_cur & ~i_prev) | (rise_reg & ~i_clr);
            fall_reg <= (~i_cur & i_prev) | (fall_reg & ~i_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // evaluate the chosen level or transition condition
    always_comb begin
        case (i_cond)
            C_ALWAYS: o_true = 1'b1;
            C_HIGH: o_true = i_cur;
            C_LOW: o_true = ~i_cur;
            C_RISE: o_true = rise_reg;
            C_FALL: o_true = fall_reg;
            C_EDGE: o_true = rise_reg | fall_reg;
            default: o_true = 1'b0;
        endcase
    end
endmodule : pint_slice

// ===== tb/pin_src.sv
// model: external pin levels on ports 0 and 1
`timescale 1ns/1ps
module pin_src
    import pint_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // pin change request
    input wire logic i_go,
    input wire logic [SEL_W-1:0] i_idx,
    input wire logic i_val,
    // pin levels
    output logic [PORT_W-1:0] o_pins
);
    // one pin changes per request edge
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pins <= '0;
        end else if (i_go) begin
            o_pins[i_idx] <= i_val;
        end
    end
endmodule : pin_src

// ===== tb/pint_checker_asserts.sv
// checker: port properties of the pin interrupt block
`timescale 1ns/1ps
module pint_checker
    import pint_pkg::*;
(
    // watched ports
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [PORT_W-1:0] i_pins,
    input wire pin_cfg_t [N_PIN-1:0] i_pin_cfg,
    input wire logic [N_PIN-1:0] i_pin_clr,
    input wire logic i_pm_enable,
    input wire logic i_event_enable,
    input wire logic i_event_pin_enable,
    input wire logic i_deep_lowpower,
    input wire grp_cfg_t [N_GRP-1:0] i_grp_cfg,
    input wire logic [N_PIN-1:0] o_pin_irq,
    input wire logic [N_SLICE-1:0] o_term_irq,
    input wire logic o_cpu_event_notify,
    input wire logic o_event_pin,
    input wire logic o_wake,
    input wire logic [N_GRP-1:0] o_grouped_input_interrupt
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_notify_gate: assert property (
        !i_event_enable |-> !o_cpu_event_notify) else $error("notify ungated");
    a_event_pin: assert property (
        o_event_pin == (o_cpu_event_notify && i_event_pin_enable))
        else $error("event pin wrong");
    a_wake_deep: assert property (
        i_deep_lowpower |-> !o_wake) else $error("wake in deep mode");
    a_wake_match: assert property (
        i_event_enable && !i_deep_lowpower |-> o_wake == o_cpu_event_notify)
        else $error("wake differs from match");
    a_term_off: assert property (
        (i_ce && !i_pm_enable) [*2] |-> o_term_irq == '0)
        else $error("term when off");
    a_edge_hold: assert property (
        o_pin_irq[0] && !i_pin_cfg[0].level && !i_pin_clr[0] |=> o_pin_irq[0])
        else $error("edge request lost");
    a_group_empty: assert property (
        (i_ce && i_grp_cfg[0].en == '0) [*4]
        |-> !o_grouped_input_interrupt[0])
        else $error("empty group fired");
    a_level_follow: assert property (
        (i_ce && i_pin_cfg[3].level && $stable(i_pins) && $stable(i_pin_cfg))
        [*4] |-> o_pin_irq[3] ==
        (i_pins[i_pin_cfg[3].sel] == i_pin_cfg[3].rise_hi))
        else $error("level request wrong");
    a_hold_frozen: assert property (
        !i_ce |=> $stable(o_pin_irq) && $stable(o_term_irq)
        && $stable(o_grouped_input_interrupt))
        else $error("state moved while frozen");
endmodule : pint_checker
bind pin_interrupt_pattern_match pint_checker u_chk (.i_clk_sys, .i_arst_n,
    .i_ce, .i_pins, .i_pin_cfg, .i_pin_clr, .i_pm_enable, .i_event_enable,
    .i_event_pin_enable, .i_deep_lowpower, .i_grp_cfg, .o_pin_irq,
    .o_term_irq, .o_cpu_event_notify, .o_event_pin, .o_wake,
    .o_grouped_input_interrupt);

// ===== tb/tb_top.sv
// bench: pin, pattern and group interrupt tests
`timescale 1ns/1ps
module tb_top
    import pint_pkg::*;
;
    logic clk, arst_n, go, val, pm, ev, evp, deep, ce;
    logic [SEL_W-1:0] idx;
    logic [PORT_W-1:0] pins;
    pin_cfg_t [N_PIN-1:0] pcfg;
    logic [N_PIN-1:0] pclr, irq, sclr, term;
    slice_cfg_t [N_SLICE-1:0] scfg;
    grp_cfg_t [N_GRP-1:0] gcfg;
    logic [N_GRP-1:0] grp;
    logic ntf, evpin, wake;
    int errors = 0, num_checks = 0, cyc = 0;
    pin_src u_pins (.i_clk_sys(clk), .i_arst_n(arst_n), .i_go(go),
        .i_idx(idx), .i_val(val), .o_pins(pins));
    pin_interrupt_pattern_match dut (.i_clk_sys(clk), .i_arst_n(arst_n),
        .i_ce(ce), .i_pins(pins), .i_pin_cfg(pcfg), .i_pin_clr(pclr),
        .i_pm_enable(pm), .i_slice_cfg(scfg), .i_slice_clr(sclr),
        .i_event_enable(ev), .i_event_pin_enable(evp),
        .i_deep_lowpower(deep), .i_grp_cfg(gcfg), .o_pin_irq(irq),
        .o_term_irq(term), .o_cpu_event_notify(ntf), .o_event_pin(evpin),
        .o_wake(wake), .o_grouped_input_interrupt(grp));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one pin change, then let it pass the synchroniser
    task automatic pin(input logic [SEL_W-1:0] i, input logic v);
        go <= 1'b1;
        idx <= i;
        val <= v;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : pin
    task automatic wt;
        repeat (5) @(posedge clk);
    endtask : wt
    initial begin
        arst_n = 1'b0; go = 1'b0; val = 1'b0; idx = '0; pm = 1'b0;
        ev = 1'b0; evp = 1'b0; deep = 1'b0; pcfg = '0; pclr = '0;
        sclr = '0; gcfg = '0; ce = 1'b1;
        for (int s = 0; s < N_SLICE; s++) scfg[s] = '{6'h00, C_NEVER, 1'b1};
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        pcfg[0] <= '{6'h05, 1'b0, 1'b1, 1'b0};
        pcfg[1] <= '{6'h28, 1'b0, 1'b0, 1'b1};
        pcfg[2] <= '{6'h28, 1'b0, 1'b1, 1'b1};
        pcfg[3] <= '{6'h28, 1'b1, 1'b0, 1'b0};
        pcfg[4] <= '{6'h28, 1'b1, 1'b1, 1'b0};
        wt();
        pin(6'h05, 1'b1); chk(irq, 8'h09);
        pin(6'h05, 1'b0); chk(irq, 8'h09);
        pin(6'h28, 1'b1); chk(irq, 8'h15);
        pclr <= 8'h07;
        @(posedge clk);
        pclr <= 8'h00;
        wt(); chk(irq, 8'h10);
        pin(6'h28, 1'b0); chk(irq, 8'h0E);
        $display("test pins done");
        scfg[0] <= '{6'h05, C_HIGH, 1'b0};
        scfg[1] <= '{6'h28, C_HIGH, 1'b1};
        scfg[2] <= '{6'h3F, C_RISE, 1'b1};
        scfg[3] <= '{6'h05, C_LOW, 1'b1};
        scfg[4] <= '{6'h3F, C_FALL, 1'b1};
        scfg[5] <= '{6'h3F, C_EDGE, 1'b1};
        scfg[6] <= '{6'h00, C_ALWAYS, 1'b1};
        pm <= 1'b1; ev <= 1'b1; evp <= 1'b1;
        wt(); chk(term, 8'h48);
        chk({ntf, evpin, wake}, 8'h07);
        pin(6'h3F, 1'b1); chk(term, 8'h6C);
        pin(6'h05, 1'b1);
        pin(6'h28, 1'b1); chk(term, 8'h66);
        pin(6'h3F, 1'b0); chk(term, 8'h76);
        sclr <= 8'hFF;
        @(posedge clk);
        sclr <= 8'h00;
        wt(); chk(term, 8'h42);
        deep <= 1'b1; ev <= 1'b0;
        wt(); chk({ntf, evpin, wake}, 8'h00);
        deep <= 1'b0;
        wt(); chk({ntf, evpin, wake}, 8'h01);
        ev <= 1'b1;
        evp <= 1'b0;
        wt();
        chk({ntf, evpin, wake}, 8'h05);
        deep <= 1'b1;
        wt();
        chk({ntf, evpin, wake}, 8'h04);
        $display("test pattern done");
        gcfg[0] <= '{64'h0000010000000020, 64'h0000010000000020, 1'b1};
        gcfg[1] <= '{64'h0000010000000020, 64'h0000000000000000, 1'b0};
        wt(); chk(grp, 8'h01);
        pin(6'h28, 1'b0); chk(grp, 8'h02);
        $display("test groups done");
        ce <= 1'b0;
        pclr <= 8'h0F;
        pin(6'h28, 1'b1);
        chk(irq, 8'h0F);
        ce <= 1'b1;
        pclr <= 8'h00;
        wt();
        chk(irq, 8'h17);
        chk(grp, 8'h01);
        gcfg[0] <= '{64'h0000000000000000, 64'h0000000000000000, 1'b1};
        wt();
        chk(grp, 8'h00);
        $display("test enable done");
        report_and_stop();
    end
endmodule : tb_top
